// [core/tai_defs.vh]
// Contract
// - Prescaler read: upper count nibble to B, lower nibble to A.
// - Prescaler write: B upper, A lower into count and reload together.
// - Timer 1 read: count bits 7..4 to B, bits 3..0 to A.
// - Timer 1 write: B upper, A lower into count and reload.
// - Timer 1 reload write: reload only from B and A, count untouched.
// - Timer 2 read: upper count nibble to B, lower to A.
// - Timer 2 low write: B and A into count and low reload.
// - Timer 2 high write: B and A into the high reload register.
// - Timer 2 reload: low reload register copied into timer 2 count.
// - Segment timer write: A into segment count and its reload at once.
// - Timer 1 skip with enable 0: skip and clear when flag set.
// - Timer 1 enable is control one bit 2; set makes skip a no-op.
// - Timer 2 skip acts only while control one bit 3 is 0.
// - Timer 3 skip acts only while control two bit 0 is 0.
`ifndef TAI_DEFS_VH
`define TAI_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define TAI_OFS_CMD 8'h00
`define TAI_OFS_RESULT 8'h04
`define TAI_OFS_ICTL1 8'h08
`define TAI_OFS_ICTL2 8'h0c
`define TAI_OFS_PRESC 8'h10
`define TAI_OFS_TMR1 8'h14
`define TAI_OFS_TMR2 8'h18
`define TAI_OFS_SEG 8'h1c
`define TAI_OFS_REQ 8'h20
`define TAI_OFS_ISTAT 8'h24
`define TAI_OFS_IMASK 8'h28

// ****************************************
// Operation codes in the command register
// ****************************************
`define TAI_OP_NOP 4'h0
`define TAI_OP_RD_PRES 4'h1
`define TAI_OP_WR_PRES 4'h2
`define TAI_OP_RD_T1 4'h3
`define TAI_OP_WR_T1 4'h4
`define TAI_OP_WR_T1_RLD 4'h5
`define TAI_OP_RD_T2 4'h6
`define TAI_OP_WR_T2_LO 4'h7
`define TAI_OP_WR_T2_HI 4'h8
`define TAI_OP_RELOAD_T2 4'h9
`define TAI_OP_WR_SEG 4'ha
`define TAI_OP_SKIP_T1 4'hb
`define TAI_OP_SKIP_T2 4'hc
`define TAI_OP_SKIP_T3 4'hd

// ****************************************
// Field positions and widths
// ****************************************
`define TAI_NIB_W 4
`define TAI_BYTE_W 8
`define TAI_CMD_OP_LSB 0
`define TAI_CMD_A_LSB 4
`define TAI_CMD_B_LSB 8
`define TAI_V1_T1_EN 2
`define TAI_V1_T2_EN 3
`define TAI_V2_T3_EN 0
`define TAI_EVT_W 4
`define TAI_EVT_SKIP 3

// ****************************************
// Reset values
// ****************************************
`define TAI_RST_BYTE 8'h00
`define TAI_RST_NIB 4'h0
`define TAI_RST_WORD 32'h00000000

`endif

// [core/tai_nib_reg.v]
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Loadable timer resource register
// ****************************************
module tai_nib_reg #(
	parameter W = 8,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input wire clk_sys,
	input wire rst,
	input wire load,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);

	// Takes d on load, holds otherwise
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			q <= RST_VAL;
		else if (load)
			q <= d;
	end

endmodule
`default_nettype wire

// [core/tai_timer_access.v]
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tai_defs.vh"

// ****************************************
// Timer access instruction unit with APB slave
// ****************************************
module tai_timer_access #(
	parameter ADDR_W = 8
) (
	input wire clk_sys,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire timerOneEvt,
	input wire timerTwoEvt,
	input wire timerThreeEvt,
	output reg [3:0] accA,
	output reg [3:0] accB,
	output reg skipNext,
	output reg opDone,
	output reg irq
);

	// ****************************************
	// Declarations
	// ****************************************
	wire setupPh;
	wire wrEn;
	wire cmdGo;
	wire [3:0] op;
	wire [3:0] aIn;
	wire [3:0] bIn;
	wire [7:0] wrByte;
	wire [7:0] adr;
	wire [7:0] presCnt;
	wire [7:0] presRld;
	wire [7:0] t1Cnt;
	wire [7:0] t1Rld;
	wire [7:0] t2Cnt;
	wire [7:0] t2Lo;
	wire [7:0] t2Hi;
	wire [3:0] segCnt;
	wire [3:0] segRld;
	wire [7:0] t2CntD;
	wire [2:0] reqSet;
	wire [3:0] evtNow;
	reg ldPresCnt;
	reg ldPresRld;
	reg ldT1Cnt;
	reg ldT1Rld;
	reg ldT2Cnt;
	reg ldT2Lo;
	reg ldT2Hi;
	reg ldSeg;
	reg t2FromLo;
	reg ldRes;
	reg [7:0] resNxt;
	reg skipTake;
	reg [2:0] clrReq;
	reg mapped;
	reg [31:0] rdMux;
	reg [15:0] cmd_r;
	reg skip_r;
	reg [3:0] ictl1_r;
	reg [3:0] ictl2_r;
	reg [2:0] req_r;
	reg [3:0] istat_r;
	reg [3:0] imask_r;

	// ****************************************
	// APB phases and command fields
	// ****************************************
	assign adr = paddr[7:0];
	assign setupPh = psel & ~penable;
	assign wrEn = psel & penable & pready & pwrite & ~pslverr;
	assign cmdGo = wrEn & (adr == `TAI_OFS_CMD);
	assign op = pwdata[`TAI_CMD_OP_LSB+3:`TAI_CMD_OP_LSB];
	assign aIn = pwdata[`TAI_CMD_A_LSB+3:`TAI_CMD_A_LSB];
	assign bIn = pwdata[`TAI_CMD_B_LSB+3:`TAI_CMD_B_LSB];
	assign wrByte = {bIn, aIn};
	// Address decode for mapped offsets
	always @*
	begin
		case (adr)
			`TAI_OFS_CMD, `TAI_OFS_RESULT, `TAI_OFS_ICTL1, `TAI_OFS_ICTL2,
			`TAI_OFS_PRESC, `TAI_OFS_TMR1, `TAI_OFS_TMR2, `TAI_OFS_SEG,
			`TAI_OFS_REQ, `TAI_OFS_ISTAT, `TAI_OFS_IMASK:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end
	// Zero wait state answer, error on unmapped offsets
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `TAI_RST_WORD;
		end
		else
		begin
			pready <= setupPh;
			pslverr <= setupPh & ~mapped;
			prdata <= (setupPh & ~pwrite) ? rdMux : `TAI_RST_WORD;
		end
	end

	// ****************************************
	// Instruction decode, single cycle
	// ****************************************
	always @*
	begin
		ldPresCnt = 1'b0;
		ldPresRld = 1'b0;
		ldT1Cnt = 1'b0;
		ldT1Rld = 1'b0;
		ldT2Cnt = 1'b0;
		ldT2Lo = 1'b0;
		ldT2Hi = 1'b0;
		ldSeg = 1'b0;
		t2FromLo = 1'b0;
		ldRes = 1'b0;
		resNxt = {accB, accA};
		skipTake = 1'b0;
		clrReq = 3'b000;
		if (cmdGo)
		begin
			case (op)
				`TAI_OP_RD_PRES:
				begin
					ldRes = 1'b1;
					resNxt = presCnt;
				end
				`TAI_OP_WR_PRES:
				begin
					ldPresCnt = 1'b1;
					ldPresRld = 1'b1;
				end
				`TAI_OP_RD_T1:
				begin
					ldRes = 1'b1;
					resNxt = t1Cnt;
				end
				`TAI_OP_WR_T1:
				begin
					ldT1Cnt = 1'b1;
					ldT1Rld = 1'b1;
				end
				`TAI_OP_WR_T1_RLD:
					ldT1Rld = 1'b1;
				`TAI_OP_RD_T2:
				begin
					ldRes = 1'b1;
					resNxt = t2Cnt;
				end
				`TAI_OP_WR_T2_LO:
				begin
					ldT2Cnt = 1'b1;
					ldT2Lo = 1'b1;
				end
				`TAI_OP_WR_T2_HI:
					ldT2Hi = 1'b1;
				`TAI_OP_RELOAD_T2:
				begin
					ldT2Cnt = 1'b1;
					t2FromLo = 1'b1;
				end
				`TAI_OP_WR_SEG:
					ldSeg = 1'b1;
				`TAI_OP_SKIP_T1:
				begin
					if (!ictl1_r[`TAI_V1_T1_EN])
					begin
						skipTake = req_r[0];
						clrReq[0] = req_r[0];
					end
				end
				`TAI_OP_SKIP_T2:
				begin
					if (!ictl1_r[`TAI_V1_T2_EN])
					begin
						skipTake = req_r[1];
						clrReq[1] = req_r[1];
					end
				end
				`TAI_OP_SKIP_T3:
				begin
					if (!ictl2_r[`TAI_V2_T3_EN])
					begin
						skipTake = req_r[2];
						clrReq[2] = req_r[2];
					end
				end
				default:
					ldRes = 1'b0;
			endcase
		end
	end

	// ****************************************
	// Timer resources
	// ****************************************
	assign t2CntD = t2FromLo ? t2Lo : wrByte;
	// Prescaler count and reload
	tai_nib_reg #(.W(`TAI_BYTE_W), .RST_VAL(`TAI_RST_BYTE)) uPresCnt (
		.clk_sys(clk_sys), .rst(rst), .load(ldPresCnt), .d(wrByte), .q(presCnt)
	);
	tai_nib_reg #(.W(`TAI_BYTE_W), .RST_VAL(`TAI_RST_BYTE)) uPresRld (
		.clk_sys(clk_sys), .rst(rst), .load(ldPresRld), .d(wrByte), .q(presRld)
	);
	// Timer 1 count and reload
	tai_nib_reg #(.W(`TAI_BYTE_W), .RST_VAL(`TAI_RST_BYTE)) uT1Cnt (
		.clk_sys(clk_sys), .rst(rst), .load(ldT1Cnt), .d(wrByte), .q(t1Cnt)
	);
	tai_nib_reg #(.W(`TAI_BYTE_W), .RST_VAL(`TAI_RST_BYTE)) uT1Rld (
		.clk_sys(clk_sys), .rst(rst), .load(ldT1Rld), .d(wrByte), .q(t1Rld)
	);
	// Timer 2 count, low and high reload
	tai_nib_reg #(.W(`TAI_BYTE_W), .RST_VAL(`TAI_RST_BYTE)) uT2Cnt (
		.clk_sys(clk_sys), .rst(rst), .load(ldT2Cnt), .d(t2CntD), .q(t2Cnt)
	);
	tai_nib_reg #(.W(`TAI_BYTE_W), .RST_VAL(`TAI_RST_BYTE)) uT2Lo (
		.clk_sys(clk_sys), .rst(rst), .load(ldT2Lo), .d(wrByte), .q(t2Lo)
	);
	tai_nib_reg #(.W(`TAI_BYTE_W), .RST_VAL(`TAI_RST_BYTE)) uT2Hi (
		.clk_sys(clk_sys), .rst(rst), .load(ldT2Hi), .d(wrByte), .q(t2Hi)
	);
	// Segment drive timer count and reload, A only
	tai_nib_reg #(.W(`TAI_NIB_W), .RST_VAL(`TAI_RST_NIB)) uSegCnt (
		.clk_sys(clk_sys), .rst(rst), .load(ldSeg), .d(aIn), .q(segCnt)
	);
	tai_nib_reg #(.W(`TAI_NIB_W), .RST_VAL(`TAI_RST_NIB)) uSegRld (
		.clk_sys(clk_sys), .rst(rst), .load(ldSeg), .d(aIn), .q(segRld)
	);

	// ****************************************
	// Accumulator pair and skip result
	// ****************************************
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			accA <= `TAI_RST_NIB;
			accB <= `TAI_RST_NIB;
			skip_r <= 1'b0;
			skipNext <= 1'b0;
			opDone <= 1'b0;
			cmd_r <= 16'h0000;
		end
		else
		begin
			if (ldRes)
			begin
				accB <= resNxt[7:4];
				accA <= resNxt[3:0];
			end
			else if (cmdGo)
			begin
				accB <= bIn;
				accA <= aIn;
			end
			if (cmdGo)
			begin
				skip_r <= skipTake;
				cmd_r <= pwdata[15:0];
			end
			skipNext <= skipTake;
			opDone <= cmdGo;
		end
	end

	// ****************************************
	// Interrupt control and request flags
	// ****************************************
	assign reqSet = {timerThreeEvt, timerTwoEvt, timerOneEvt};
	assign evtNow = {skipTake, reqSet};
	// Control registers written by software
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ictl1_r <= `TAI_RST_NIB;
			ictl2_r <= `TAI_RST_NIB;
			imask_r <= `TAI_RST_NIB;
		end
		else if (wrEn)
		begin
			if (adr == `TAI_OFS_ICTL1)
				ictl1_r <= pwdata[3:0];
			if (adr == `TAI_OFS_ICTL2)
				ictl2_r <= pwdata[3:0];
			if (adr == `TAI_OFS_IMASK)
				imask_r <= pwdata[3:0];
		end
	end
	// Request flags, a new event beats a skip clear
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			req_r <= 3'b000;
		else
			req_r <= (req_r & ~clrReq) | reqSet;
	end
	// Sticky status, write one to clear, event beats clear
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			istat_r <= `TAI_RST_NIB;
		else if (wrEn && (adr == `TAI_OFS_ISTAT))
			istat_r <= (istat_r & ~pwdata[3:0]) | evtNow;
		else
			istat_r <= istat_r | evtNow;
	end
	// Level interrupt from unmasked status
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(istat_r & imask_r);
	end

	// ****************************************
	// Read data selection
	// ****************************************
	always @*
	begin
		rdMux = `TAI_RST_WORD;
		case (adr)
			`TAI_OFS_CMD:
				rdMux = {16'h0000, cmd_r};
			`TAI_OFS_RESULT:
				rdMux = {23'h0, skip_r, accB, accA};
			`TAI_OFS_ICTL1:
				rdMux = {28'h0000000, ictl1_r};
			`TAI_OFS_ICTL2:
				rdMux = {28'h0000000, ictl2_r};
			`TAI_OFS_PRESC:
				rdMux = {16'h0000, presRld, presCnt};
			`TAI_OFS_TMR1:
				rdMux = {16'h0000, t1Rld, t1Cnt};
			`TAI_OFS_TMR2:
				rdMux = {8'h00, t2Hi, t2Lo, t2Cnt};
			`TAI_OFS_SEG:
				rdMux = {24'h000000, segRld, segCnt};
			`TAI_OFS_REQ:
				rdMux = {29'h0, req_r};
			`TAI_OFS_ISTAT:
				rdMux = {28'h0000000, istat_r};
			`TAI_OFS_IMASK:
				rdMux = {28'h0000000, imask_r};
			default:
				rdMux = `TAI_RST_WORD;
		endcase
	end

endmodule
`default_nettype wire

// [testbench/tai_timer_access_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checker
// ****
module tai_timer_access_chk #(
	parameter ADDR_W = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] accA,
	input wire logic [3:0] accB,
	input wire logic skipNext,
	input wire logic opDone
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic cmdWr;
	// Command write completing in this cycle
	assign cmdWr = psel && penable && pready && pwrite && paddr == 'h0;
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held");
	a_done_per_cmd: assert property (cmdWr |=> opDone)
		else $error("no done after command");
	a_done_cause: assert property (opDone |-> $past(cmdWr))
		else $error("stray done");
	a_acc_from_cmd: assert property (cmdWr && !(pwdata[3:0] inside {4'h1, 4'h3, 4'h6})
		|=> accA == $past(pwdata[7:4]) && accB == $past(pwdata[11:8]))
		else $error("accumulators not loaded");
	a_acc_hold: assert property (!$past(cmdWr) |-> $stable(accA) && $stable(accB))
		else $error("accumulators moved");
	a_skip_cause: assert property (skipNext |-> opDone
		&& $past(pwdata[3:0]) inside {4'hb, 4'hc, 4'hd})
		else $error("skip without skip op");
	a_err_unmapped: assert property (psel && !penable && paddr > 'h28
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped not refused");
endmodule
bind tai_timer_access tai_timer_access_chk #(.ADDR_W(ADDR_W)) chk_u (.clk_sys, .rst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .accA,
	.accB, .skipNext, .opDone);
`default_nettype wire

// [testbench/tai_timer_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****
// Timer hardware events
// ****
module tai_timer_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [2:0] fireReq,
	input wire logic [3:0] lag,
	output logic [2:0] evtOut
);
	logic [2:0] pendR;
	logic [3:0] cntR;
	// Hold a request for lag cycles, then pulse once
	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pendR <= 3'h0;
			cntR <= 4'h0;
			evtOut <= 3'h0;
		end
		else if (fireReq != 3'h0)
		begin
			pendR <= fireReq;
			cntR <= lag;
			evtOut <= 3'h0;
		end
		else
		begin
			evtOut <= (cntR == 4'h0) ? pendR : 3'h0;
			if (cntR == 4'h0)
				pendR <= 3'h0;
			else
				cntR <= cntR - 4'h1;
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_timer_access_instruction_unit.sv]
`timescale 1ns/10ps
`default_nettype none
`include "tai_defs.vh"
// ****
// Bench
// ****
module tb_timer_access_instruction_unit;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, skipNext, opDone, irq, err;
	logic [3:0] accA, accB, skOp;
	logic [3:0] lag = 4'h0;
	logic [2:0] fireReq = 3'h0;
	logic [2:0] evt;
	logic [7:0] ctl;
	int fails = 0;
	int num_checks = 0;
	int t, n;
	// System clock
	always #4 clk_sys = ~clk_sys;
	// Block and timer side
	tai_timer_access dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .timerOneEvt(evt[0]), .timerTwoEvt(evt[1]),
		.timerThreeEvt(evt[2]), .accA, .accB, .skipNext, .opDone, .irq);
	tai_timer_model tmr_u (.clk_sys, .rst, .fireReq, .lag, .evtOut(evt));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
	begin
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s exp %h seen %h", name, exp, seen);
		end
	end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
	begin
		apb(1'b0, a, 32'h0);
		chk($sformatf("addr %h", a), rdat, exp);
		chk("pslverr", err, 32'h0);
	end
	endtask
	task automatic op(input logic [3:0] code, input logic [7:0] f, input logic [7:0] e);
	begin
		apb(1'b1, `TAI_OFS_CMD, {20'h0, f, code});
		#1;
		chk("opDone", opDone, 32'h1);
		chk("acc", {accB, accA}, e);
	end
	endtask
	task automatic tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	// Watchdog
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		tally_and_finish();
	end
	// Tests
	initial
	begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`TAI_OFS_RESULT, 32'h0);
		op(`TAI_OP_WR_PRES, 8'ha5, 8'ha5);
		rd(`TAI_OFS_PRESC, 32'ha5a5);
		op(`TAI_OP_RD_PRES, 8'h00, 8'ha5);
		$display("prescaler done");
		op(`TAI_OP_WR_T1, 8'hc3, 8'hc3);
		rd(`TAI_OFS_TMR1, 32'hc3c3);
		op(`TAI_OP_WR_T1_RLD, 8'h21, 8'h21);
		rd(`TAI_OFS_TMR1, 32'h21c3);
		op(`TAI_OP_RD_T1, 8'h00, 8'hc3);
		op(`TAI_OP_WR_T2_LO, 8'h76, 8'h76);
		op(`TAI_OP_WR_T2_HI, 8'h89, 8'h89);
		rd(`TAI_OFS_TMR2, 32'h897676);
		op(`TAI_OP_RD_T2, 8'h00, 8'h76);
		op(`TAI_OP_RELOAD_T2, 8'h00, 8'h00);
		rd(`TAI_OFS_TMR2, 32'h897676);
		op(`TAI_OP_WR_SEG, 8'h04, 8'h04);
		rd(`TAI_OFS_SEG, 32'h44);
		op(`TAI_OP_NOP, 8'h5a, 8'h5a);
		rd(`TAI_OFS_PRESC, 32'ha5a5);
		op(4'hf, 8'h3c, 8'h3c);
		rd(`TAI_OFS_TMR1, 32'h21c3);
		$display("transfers done");
		for (t = 0; t < 3; t++)
		begin
			ctl = (t == 2) ? `TAI_OFS_ICTL2 : `TAI_OFS_ICTL1;
			skOp = `TAI_OP_SKIP_T1 + 4'(t);
			lag <= 4'(t * 7);
			fireReq <= 3'h1 << t;
			@(posedge clk_sys);
			fireReq <= 3'h0;
			for (n = 0; n < 30 && evt == 3'h0; n++)
				@(posedge clk_sys);
			@(posedge clk_sys);
			apb(1'b1, ctl, (t == 0) ? 32'h4 : (t == 1) ? 32'h8 : 32'h1);
			op(skOp, 8'h00, 8'h00);
			chk("skipNext", skipNext, 32'h0);
			rd(`TAI_OFS_REQ, 32'h1 << t);
			apb(1'b1, ctl, 32'h0);
			op(skOp, 8'h00, 8'h00);
			chk("skipNext", skipNext, 32'h1);
			rd(`TAI_OFS_REQ, 32'h0);
			op(skOp, 8'h00, 8'h00);
			chk("skipNext", skipNext, 32'h0);
		end
		$display("skips done");
		rd(`TAI_OFS_ISTAT, 32'hf);
		chk("irq", irq, 32'h0);
		apb(1'b1, `TAI_OFS_IMASK, 32'h2);
		@(posedge clk_sys);
		#1;
		chk("irq", irq, 32'h1);
		apb(1'b1, `TAI_OFS_ISTAT, 32'h2);
		@(posedge clk_sys);
		#1;
		chk("irq", irq, 32'h0);
		rd(`TAI_OFS_ISTAT, 32'hd);
		apb(1'b0, 8'h3c, 32'h0);
		chk("pslverr", err, 32'h1);
		$display("interrupts done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
